// [i2ce_top.sv]
// two-wire interface event flags, interrupt request and wait/halt behaviour
//
// Summary of operation
// - in wait the interface runs on; a pending request ends wait
// - in halt registers freeze, interface idles and never acknowledges
// - after halt, operation resumes only once a halt-capable wake arrives
// - master: flag raised once a 10-bit address header is sent
// - flag raised each time a full data byte has shifted
// - slave: flag raised when received address equals own address
// - master: flag raised once a start condition is generated
// - separate flags for missing ack, slave stop detect, bus error
// - multimaster: flag raised when arbitration is lost
// - all events share one request under one enable and a per-flag mask; none ends halt
// - request reaches core only with enable set and core mask clear
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "i2ce_map.svh"
module i2ce_top (
   input  wire logic                 I_CLK,
   input  wire logic                 I_NRST,
   input  wire i2ce_pkg::i2ce_addr_t I_ADDR,
   input  wire i2ce_pkg::i2ce_byte_t I_WDATA,
   input  wire logic                 I_WR,
   input  wire logic                 I_RD,
   output i2ce_pkg::i2ce_byte_t      O_RDATA,
   input  wire logic                 I_SCL,
   input  wire logic                 I_SDA,
   output logic                      O_SDA_O,
   output logic                      O_SDA_OE_N,
   input  wire logic                 I_EV_EXT_ADDR_SENT,
   input  wire logic                 I_EV_BYTE_DONE,
   input  wire logic                 I_EV_START_SENT,
   input  wire logic                 I_EV_ACK_FAIL,
   input  wire logic                 I_EV_ARB_LOST,
   input  wire logic                 I_CORE_IMASK,
   input  wire logic                 I_WAIT,
   input  wire logic                 I_HALT_ENTER,
   input  wire logic                 I_HALT_WAKE,
   output logic                      O_IRQ,
   output logic                      O_WAIT_EXIT,
   output logic                      O_HALTED
);
   import i2ce_pkg::*;

   logic              rst_meta_r;
   logic              rst_n_s;
   logic              scl_s;
   logic              sda_s;
   logic              scl_q_r;
   logic              sda_q_r;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_det;
   logic              stop_det;
   i2ce_byte_t        ctrl_r;
   logic [6:0]        own_addr_r;
   i2ce_flags_t       mask_r;
   i2ce_flags_t       flags;
   i2ce_flags_t       set_vec;
   i2ce_flags_t       clr_vec;
   logic              halted_r;
   i2ce_bus_st_t      st_r;
   logic [`I2CE_BIT_CNT_W-1:0] bit_cnt_r;
   i2ce_byte_t        shift_r;
   i2ce_byte_t        byte_nxt;
   logic              addressed_r;
   logic              rd_dir_r;
   logic              ack_pend_r;
   logic              match_nxt;
   logic              in_byte;
   logic              last_bit;
   logic              ev_byte;
   logic              ev_match;
   logic              ev_ackf;
   logic              ev_stop;
   logic              ev_bus_fault_flag;
   logic              pending;
   logic              wr_ok;

   i2ce_flag_if #(.N(`I2CE_NFLAGS)) fl_if ();

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_meta_r <= 1'b0;
         rst_n_s    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_s    <= rst_meta_r;
      end
   end

   // idle bus lines float high, so the synchronisers reset high
   i2ce_sync #(.W(2), .RST_VAL(1'b1)) u_line_sync (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n_s),
      .i_d     ({I_SCL, I_SDA}),
      .o_q     ({scl_s, sda_s})
   );

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_q_r;
   assign scl_fall  = ~scl_s & scl_q_r;
   assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // halt state: left only by a wake source able to end halt

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         halted_r <= 1'b0;
      end else if (halted_r) begin
         // our own request is deliberately not a wake source here
         halted_r <= ~I_HALT_WAKE;
      end else begin
         halted_r <= I_HALT_ENTER;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes, frozen in halt; wait has no effect at all

   assign wr_ok = I_WR & ~halted_r;

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ctrl_r     <= `I2CE_RST_CTRL;
         own_addr_r <= `I2CE_RST_OWN_ADDR;
         mask_r     <= `I2CE_RST_MASK;
      end else if (wr_ok) begin
         case (I_ADDR)
            `I2CE_OFS_CTRL:     ctrl_r     <= I_WDATA;
            `I2CE_OFS_OWN_ADDR: own_addr_r <= I_WDATA[6:0];
            `I2CE_OFS_MASK:     mask_r     <= I_WDATA;
            default:            ;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         O_RDATA <= `I2CE_RD_ZERO;
      end else if (I_RD) begin
         case (I_ADDR)
            `I2CE_OFS_CTRL:     O_RDATA <= ctrl_r;
            `I2CE_OFS_OWN_ADDR: O_RDATA <= {1'b0, own_addr_r};
            `I2CE_OFS_STATUS:   O_RDATA <= flags;
            `I2CE_OFS_MASK:     O_RDATA <= mask_r;
            `I2CE_OFS_STATE: begin
               O_RDATA                     <= `I2CE_RD_ZERO;
               O_RDATA[`I2CE_ST_HALTED]    <= halted_r;
               O_RDATA[`I2CE_ST_ADDRESSED] <= addressed_r;
               O_RDATA[`I2CE_ST_RD_DIR]    <= rd_dir_r;
               O_RDATA[`I2CE_ST_BUSY]      <= (st_r != BS_IDLE);
            end
            default:            O_RDATA <= `I2CE_RD_ZERO;
         endcase
      end else begin
         O_RDATA <= `I2CE_RD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave-side bus monitor

   assign byte_nxt  = {shift_r[6:0], sda_s};
   assign match_nxt = ctrl_r[`I2CE_CTRL_SLV_EN] & (byte_nxt[7:1] == own_addr_r);
   assign in_byte   = (st_r == BS_ADDR) | (st_r == BS_DATA);
   assign last_bit  = scl_rise & (bit_cnt_r == `I2CE_LAST_BIT);

   assign ev_match = last_bit & (st_r == BS_ADDR) & match_nxt;
   assign ev_byte  = last_bit & ((st_r == BS_DATA) | ev_match);
   // only a missing ack while we transmit is ours to report
   assign ev_ackf  = scl_rise & (bit_cnt_r == `I2CE_ACK_BIT) & (st_r == BS_DATA)
                     & rd_dir_r & sda_s;
   assign ev_stop  = stop_det & addressed_r;
   // a stop or repeated start sits in the first bit slot of a byte, so that slot is legal
   assign ev_bus_fault_flag  = (start_det | stop_det) & in_byte & (bit_cnt_r > `I2CE_CNT_ONE);

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         st_r        <= BS_IDLE;
         bit_cnt_r   <= `I2CE_CNT_ZERO;
         shift_r     <= `I2CE_RD_ZERO;
         addressed_r <= 1'b0;
         rd_dir_r    <= 1'b0;
         ack_pend_r  <= 1'b0;
      end else if (halted_r) begin
         st_r        <= BS_IDLE;
         bit_cnt_r   <= `I2CE_CNT_ZERO;
         addressed_r <= 1'b0;
         ack_pend_r  <= 1'b0;
      end else if (start_det) begin
         st_r        <= BS_ADDR;
         bit_cnt_r   <= `I2CE_CNT_ZERO;
         addressed_r <= 1'b0;
         ack_pend_r  <= 1'b0;
      end else if (stop_det) begin
         st_r        <= BS_IDLE;
         bit_cnt_r   <= `I2CE_CNT_ZERO;
         addressed_r <= 1'b0;
         ack_pend_r  <= 1'b0;
      end else begin
         case (st_r)
            BS_ADDR, BS_DATA: begin
               if (scl_rise && bit_cnt_r != `I2CE_ACK_BIT) begin
                  shift_r   <= byte_nxt;
                  bit_cnt_r <= bit_cnt_r + `I2CE_CNT_ONE;
                  if (ev_match) begin
                     addressed_r <= 1'b1;
                     rd_dir_r    <= byte_nxt[0];
                     ack_pend_r  <= 1'b1;
                  end else if (last_bit && st_r == BS_DATA) begin
                     ack_pend_r  <= ~rd_dir_r;
                  end
               end else if (scl_rise) begin
                  bit_cnt_r <= `I2CE_CNT_ZERO;
                  if (st_r == BS_ADDR) begin
                     st_r <= addressed_r ? BS_DATA : BS_SKIP;
                  end
               end else if (scl_fall && bit_cnt_r == `I2CE_CNT_ZERO) begin
                  ack_pend_r <= 1'b0;
               end
            end
            BS_IDLE, BS_SKIP: ;
            default: st_r <= BS_IDLE;
         endcase
      end
   end

   // ack pulls SDA low from the falling edge before the ack bit to the one after
   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         O_SDA_O    <= 1'b0;
         O_SDA_OE_N <= 1'b1;
      end else if (halted_r || start_det || stop_det) begin
         O_SDA_O    <= 1'b0;
         O_SDA_OE_N <= 1'b1;
      end else if (scl_fall && bit_cnt_r == `I2CE_ACK_BIT && ack_pend_r) begin
         O_SDA_O    <= 1'b0;
         O_SDA_OE_N <= 1'b0;
      end else if (scl_fall && bit_cnt_r == `I2CE_CNT_ZERO) begin
         O_SDA_O    <= 1'b0;
         O_SDA_OE_N <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event flags and the single shared request

   always_comb begin
      set_vec                        = '0;
      set_vec[`I2CE_FL_EXT_ADDR]     = I_EV_EXT_ADDR_SENT;
      set_vec[`I2CE_FL_BYTE_DONE]    = I_EV_BYTE_DONE | ev_byte;
      set_vec[`I2CE_FL_ADDR_MATCH]   = ev_match;
      set_vec[`I2CE_FL_START_SENT]   = I_EV_START_SENT;
      set_vec[`I2CE_FL_ACK_FAIL]     = I_EV_ACK_FAIL | ev_ackf;
      set_vec[`I2CE_FL_STOP_SEEN]    = ev_stop;
      set_vec[`I2CE_FL_ARB_LOST]     = I_EV_ARB_LOST;
      set_vec[`I2CE_FL_BUS_FAULT]    = ev_bus_fault_flag;
   end

   assign clr_vec = (wr_ok && I_ADDR == `I2CE_OFS_STATUS) ? I_WDATA : '0;

   assign fl_if.set  = set_vec;
   assign fl_if.clr  = clr_vec;
   assign fl_if.hold = halted_r;
   assign flags      = fl_if.flags;

   i2ce_flag_bank #(.N(`I2CE_NFLAGS)) u_flags (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n_s),
      .fb      (fl_if.bank)
   );

   assign pending = ctrl_r[`I2CE_CTRL_IRQ_EN] & (|(flags & mask_r));

   always_ff @(posedge I_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         O_IRQ       <= 1'b0;
         O_WAIT_EXIT <= 1'b0;
         O_HALTED    <= 1'b0;
      end else begin
         O_IRQ       <= pending & ~I_CORE_IMASK;
         O_WAIT_EXIT <= pending & I_WAIT;
         O_HALTED    <= halted_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!rst_n_s);

   sequence s_addr_last_bit;
      st_r == BS_ADDR && last_bit && match_nxt && !halted_r && !start_det && !stop_det;
   endsequence

   sequence s_ack_window;
      scl_fall && bit_cnt_r == `I2CE_ACK_BIT && ack_pend_r && !halted_r
         && !start_det && !stop_det;
   endsequence

   property p_irq_gate;
      pending && !I_CORE_IMASK |=> O_IRQ;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request not raised");

   property p_irq_masked;
      !ctrl_r[`I2CE_CTRL_IRQ_EN] || I_CORE_IMASK |=> !O_IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("request leaked");

   property p_wait_exit;
      I_WAIT && pending |=> O_WAIT_EXIT;
   endproperty
   a_wait_exit: assert property (p_wait_exit) else $error("wait not ended");

   property p_halt_frozen;
      halted_r && !I_HALT_WAKE |=> $stable(flags) && $stable(ctrl_r) && $stable(mask_r);
   endproperty
   a_halt_frozen: assert property (p_halt_frozen) else $error("registers moved in halt");

   property p_halt_no_ack;
      halted_r |=> O_SDA_OE_N;
   endproperty
   a_halt_no_ack: assert property (p_halt_no_ack) else $error("ack driven in halt");

   property p_halt_exit;
      halted_r && !I_HALT_WAKE |=> halted_r ##0 O_HALTED [*1];
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt left without wake");

   property p_wake;
      halted_r && I_HALT_WAKE |=> !halted_r ##1 !O_HALTED;
   endproperty
   a_wake: assert property (p_wake) else $error("wake ignored");

   property p_addr_match;
      s_addr_last_bit |=> flags[`I2CE_FL_ADDR_MATCH] && flags[`I2CE_FL_BYTE_DONE]
                          && addressed_r;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("address match lost");

   property p_ack_drive;
      s_ack_window |=> !O_SDA_OE_N && !O_SDA_O;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

   property p_start_sent;
      I_EV_START_SENT && !halted_r |=> flags[`I2CE_FL_START_SENT];
   endproperty
   a_start_sent: assert property (p_start_sent) else $error("start flag missing");

   property p_stop_seen;
      stop_det && addressed_r && !halted_r |=> flags[`I2CE_FL_STOP_SEEN] ##1 st_r == BS_IDLE;
   endproperty
   a_stop_seen: assert property (p_stop_seen) else $error("stop flag missing");

   property p_sticky;
      flags[`I2CE_FL_BUS_FAULT] && !clr_vec[`I2CE_FL_BUS_FAULT]
         |=> flags[`I2CE_FL_BUS_FAULT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

endmodule
`default_nettype wire

// [i2ce_map.svh]
// register offsets, field positions, reset values and bus-monitor counts
`ifndef I2CE_MAP_SVH
`define I2CE_MAP_SVH

`define I2CE_ADDR_W        3
`define I2CE_DATA_W        8
`define I2CE_NFLAGS        8

`define I2CE_OFS_CTRL      3'h0
`define I2CE_OFS_OWN_ADDR  3'h1
`define I2CE_OFS_STATUS    3'h2
`define I2CE_OFS_MASK      3'h3
`define I2CE_OFS_STATE     3'h4

`define I2CE_CTRL_IRQ_EN   0
`define I2CE_CTRL_SLV_EN   1

`define I2CE_ST_HALTED     0
`define I2CE_ST_ADDRESSED  1
`define I2CE_ST_RD_DIR     2
`define I2CE_ST_BUSY       3

`define I2CE_FL_EXT_ADDR   0
`define I2CE_FL_BYTE_DONE  1
`define I2CE_FL_ADDR_MATCH 2
`define I2CE_FL_START_SENT 3
`define I2CE_FL_ACK_FAIL   4
`define I2CE_FL_STOP_SEEN  5
`define I2CE_FL_ARB_LOST   6
`define I2CE_FL_BUS_FAULT  7

`define I2CE_RST_CTRL      8'h00
`define I2CE_RST_OWN_ADDR  7'h00
`define I2CE_RST_MASK      8'hFF
`define I2CE_RST_FLAGS     8'h00
`define I2CE_RD_ZERO       8'h00

`define I2CE_BIT_CNT_W     4
`define I2CE_LAST_BIT      4'h7
`define I2CE_ACK_BIT       4'h8
`define I2CE_CNT_ZERO      4'h0
`define I2CE_CNT_ONE       4'h1

`endif

// [i2ce_pkg.sv]
// shared types of the two-wire event and interrupt block
`default_nettype none
`include "i2ce_map.svh"
package i2ce_pkg;
   typedef logic [`I2CE_ADDR_W-1:0] i2ce_addr_t;
   typedef logic [`I2CE_DATA_W-1:0] i2ce_byte_t;
   typedef logic [`I2CE_NFLAGS-1:0] i2ce_flags_t;
   typedef enum logic [1:0] {BS_IDLE, BS_ADDR, BS_DATA, BS_SKIP} i2ce_bus_st_t;
endpackage
`default_nettype wire

// [i2ce_flag_if.sv]
// carrier between the top and the sticky event flag bank
`timescale 1ns/1ns
`default_nettype none
interface i2ce_flag_if #(parameter int N = 8);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic         hold;
   logic [N-1:0] flags;
   modport bank (input set, input clr, input hold, output flags);
   modport user (output set, output clr, output hold, input flags);
endinterface
`default_nettype wire

// [i2ce_sync.sv]
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module i2ce_sync #(
   parameter int W        = 1,
   parameter bit RST_VAL  = 1'b1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   generate
      if (W < 1) begin : g_bad_width
         $error("i2ce_sync: W must be at least 1");
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= {W{RST_VAL}};
         o_q    <= {W{RST_VAL}};
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [i2ce_flag_bank.sv]
// sticky event flags, set wins over write-one-to-clear, frozen on hold
`timescale 1ns/1ns
`default_nettype none
module i2ce_flag_bank #(
   parameter int N = 8
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   i2ce_flag_if.bank fb
);
   logic [N-1:0] flags_r;

   generate
      if (N < 1) begin : g_bad_n
         $error("i2ce_flag_bank: N must be at least 1");
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_r <= '0;
      end else if (!fb.hold) begin
         flags_r <= (flags_r & ~fb.clr) | fb.set;
      end
   end

   assign fb.flags = flags_r;
endmodule
`default_nettype wire

// [i2ce_master_model.sv]
// two-wire bus master model driving clock and data as open-drain lines
`timescale 1ns/1ns
`default_nettype none
module i2ce_master_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   // released lines float high through the pull-ups; clock idles between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic start_cond();
      wait_clk(1);
      o_sda <= 1'b0;
      wait_clk(4);
      o_scl <= 1'b0;
   endtask

   // msb first, data changes only while the clock is low
   task automatic send_bits(input logic [7:0] d, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         wait_clk(2);
         o_sda <= d[i];
         wait_clk(2);
         o_scl <= 1'b1;
         wait_clk(4);
         o_scl <= 1'b0;
      end
   endtask

   task automatic get_ack(output logic ack);
      wait_clk(2);
      o_sda <= 1'b1;
      wait_clk(2);
      o_scl <= 1'b1;
      wait_clk(2);
      #1 ack = ~i_sda;
      wait_clk(2);
      o_scl <= 1'b0;
   endtask

   task automatic stop_cond();
      wait_clk(2);
      o_sda <= 1'b0;
      wait_clk(2);
      o_scl <= 1'b1;
      wait_clk(4);
      o_sda <= 1'b1;
      wait_clk(4);
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the two-wire event, interrupt and low-power block
`timescale 1ns/1ns
`default_nettype none
`include "i2ce_map.svh"
module testbench;
   import i2ce_pkg::*;
   logic             clk         = 1'b0;
   logic             nrst        = 1'b0;
   i2ce_addr_t       addr        = 3'h0;
   i2ce_byte_t       wdata       = 8'h00;
   logic             wr          = 1'b0;
   logic             rd          = 1'b0;
   logic [4:0]       ev          = 5'h00;
   logic             imask       = 1'b0;
   logic             wt          = 1'b0;
   logic             halt_in     = 1'b0;
   logic             wake        = 1'b0;
   i2ce_byte_t       rdata;
   logic             scl;
   logic             m_sda;
   logic             sda_o;
   logic             sda_oe_n;
   logic             irq;
   logic             wexit;
   logic             halted;
   logic             ack;
   wire              sda_wire;
   int               errors      = 0;
   int               check_count = 0;
   int               cycles      = 0;
   int               ev_bit [5]  = '{`I2CE_FL_EXT_ADDR, `I2CE_FL_BYTE_DONE,
                                     `I2CE_FL_START_SENT, `I2CE_FL_ACK_FAIL,
                                     `I2CE_FL_ARB_LOST};

   // wired-and with pull-up: low if either party pulls low
   assign sda_wire = m_sda & (sda_oe_n | sda_o);

   initial begin
      forever #4 clk = ~clk;
   end

   i2ce_top dut (
      .I_CLK              (clk),
      .I_NRST             (nrst),
      .I_ADDR             (addr),
      .I_WDATA            (wdata),
      .I_WR               (wr),
      .I_RD               (rd),
      .O_RDATA            (rdata),
      .I_SCL              (scl),
      .I_SDA              (sda_wire),
      .O_SDA_O            (sda_o),
      .O_SDA_OE_N         (sda_oe_n),
      .I_EV_EXT_ADDR_SENT (ev[0]),
      .I_EV_BYTE_DONE     (ev[1]),
      .I_EV_START_SENT    (ev[2]),
      .I_EV_ACK_FAIL      (ev[3]),
      .I_EV_ARB_LOST      (ev[4]),
      .I_CORE_IMASK       (imask),
      .I_WAIT             (wt),
      .I_HALT_ENTER       (halt_in),
      .I_HALT_WAKE        (wake),
      .O_IRQ              (irq),
      .O_WAIT_EXIT        (wexit),
      .O_HALTED           (halted)
   );

   i2ce_master_model bus (
      .i_clk (clk),
      .i_sda (sda_wire),
      .o_scl (scl),
      .o_sda (m_sda)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input i2ce_addr_t a, input i2ce_byte_t d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input i2ce_addr_t a, input i2ce_byte_t exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // 0 strobes halt entry, 1 strobes the halt-capable wake
   task automatic pulse(input bit to_wake);
      @(posedge clk);
      if (to_wake) begin
         wake <= 1'b1;
      end else begin
         halt_in <= 1'b1;
      end
      @(posedge clk);
      wake    <= 1'b0;
      halt_in <= 1'b0;
      wait_cyc(3);
   endtask

   task automatic pulse_ev(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      wait_cyc(3);
   endtask

   task automatic frame(input i2ce_byte_t b, output logic a);
      bus.start_cond();
      bus.send_bits(b, 8);
      bus.get_ack(a);
      bus.stop_cond();
   endtask

   task automatic bit_chk(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      wait_cyc(5);
      nrst <= 1'b1;
      wait_cyc(3);
      rd_chk(`I2CE_OFS_CTRL, `I2CE_RST_CTRL);
      rd_chk(`I2CE_OFS_OWN_ADDR, {1'b0, `I2CE_RST_OWN_ADDR});
      rd_chk(`I2CE_OFS_STATUS, `I2CE_RST_FLAGS);
      rd_chk(`I2CE_OFS_MASK, `I2CE_RST_MASK);
      rd_chk(`I2CE_OFS_STATE, 8'h00);
      rd_chk(3'h5, `I2CE_RD_ZERO);
      bit_chk(sda_oe_n, 1'b1);
      $display("test reset done");

      wr_reg(`I2CE_OFS_CTRL, 8'h01);
      for (int i = 0; i < 5; i++) begin
         pulse_ev(i);
         rd_chk(`I2CE_OFS_STATUS, i2ce_byte_t'(8'h01 << ev_bit[i]));
         bit_chk(irq, 1'b1);
         wait_cyc(10);
         bit_chk(irq, 1'b1);
         wr_reg(`I2CE_OFS_STATUS, 8'hFF);
         wait_cyc(3);
         rd_chk(`I2CE_OFS_STATUS, 8'h00);
         bit_chk(irq, 1'b0);
      end
      $display("test event flags done");

      pulse_ev(2);
      @(posedge clk);
      imask <= 1'b1;
      wt    <= 1'b1;
      wait_cyc(3);
      bit_chk(irq, 1'b0);
      bit_chk(wexit, 1'b1);
      wr_reg(`I2CE_OFS_CTRL, 8'h00);
      wait_cyc(3);
      bit_chk(wexit, 1'b0);
      wr_reg(`I2CE_OFS_CTRL, 8'h01);
      wr_reg(`I2CE_OFS_MASK, 8'hF7);
      wait_cyc(3);
      bit_chk(wexit, 1'b0);
      wr_reg(`I2CE_OFS_MASK, 8'hFF);
      @(posedge clk);
      imask <= 1'b0;
      wait_cyc(3);
      bit_chk(irq, 1'b1);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      $display("test gating done");

      // slave traffic while the core waits with interrupts masked
      @(posedge clk);
      imask <= 1'b1;
      wr_reg(`I2CE_OFS_OWN_ADDR, 8'h2A);
      wr_reg(`I2CE_OFS_CTRL, 8'h03);
      frame(8'h54, ack);
      bit_chk(ack, 1'b1);
      rd_chk(`I2CE_OFS_STATUS, 8'h26);
      bit_chk(wexit, 1'b1);
      bit_chk(irq, 1'b0);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      frame(8'h56, ack);
      bit_chk(ack, 1'b0);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      bus.start_cond();
      bus.send_bits(8'h54, 3);
      bus.stop_cond();
      rd_chk(`I2CE_OFS_STATUS, 8'h80);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      $display("test slave link done");

      @(posedge clk);
      imask <= 1'b0;
      wt    <= 1'b0;
      pulse_ev(2);
      pulse(1'b0);
      bit_chk(halted, 1'b1);
      rd_chk(`I2CE_OFS_STATE, 8'h01);
      pulse_ev(1);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      rd_chk(`I2CE_OFS_STATUS, 8'h08);
      frame(8'h54, ack);
      bit_chk(ack, 1'b0);
      bit_chk(halted, 1'b1);
      pulse(1'b1);
      bit_chk(halted, 1'b0);
      frame(8'h54, ack);
      bit_chk(ack, 1'b1);
      rd_chk(`I2CE_OFS_STATUS, 8'h2E);
      wr_reg(`I2CE_OFS_STATUS, 8'hFF);
      $display("test halt done");

      // read direction: master clocks a byte with SDA released, then refuses it
      bus.start_cond();
      bus.send_bits(8'h55, 8);
      bus.get_ack(ack);
      bit_chk(ack, 1'b1);
      rd_chk(`I2CE_OFS_STATE, 8'h0E);
      bus.send_bits(8'hFF, 8);
      bus.get_ack(ack);
      bit_chk(ack, 1'b0);
      bus.stop_cond();
      rd_chk(`I2CE_OFS_STATUS, 8'h36);
      $display("test read direction done");
      stop_test();
   end
endmodule
`default_nettype wire
